// ===== design/sks_cfg.svh
// constants for the slider and key suppression block
`ifndef SKS_CFG_SVH
`define SKS_CFG_SVH
`define SKS_NKEYS        16
`define SKS_NSLD_MAX     8
`define SKS_DI_LIMIT     4'h4
`define SKS_RES_MIN      4'h2
`define SKS_RES_MAX      4'h8
`define SKS_CNT_W        4
`endif

// ===== design/sks_pkg.sv
// types shared by the slider and key suppression block
package sks_pkg;
  typedef logic [1:0] sks_grp_t;
  typedef struct packed {
    logic [15:0] key_det;
    logic        sld_det;
    logic [7:0]  sld_pos;
  } sks_status_s;
  typedef enum logic [1:0] {
    SKS_IDLE = 2'b00,
    SKS_EVAL = 2'b01
  } sks_phase_e;
endpackage : sks_pkg

// ===== design/sks_core.sv
// key integrator, slider position and neighbour suppression groups
`timescale 1ns/1ns
`default_nettype none
`include "sks_cfg.svh"
module sks_core #(
  parameter int          NK     = `SKS_NKEYS,
  parameter int          NSMAX  = `SKS_NSLD_MAX,
  parameter logic [3:0]  DI_LIM = `SKS_DI_LIMIT
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               acq_valid,
  input  wire logic [NK-1:0]      above_thr,
  input  wire logic [NK*8-1:0]    key_delta,
  input  wire logic [3:0]         slider_len,
  input  wire logic [3:0]         pos_bits,
  input  wire logic [NK*2-1:0]    neighbour_suppression_group,
  input  wire logic               change_clr,
  output var  sks_pkg::sks_status_s status_r,
  output var  logic               change_n_o_r,
  output var  logic               change_n_oe_r
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]    cnt_r [NK];
  logic [NK-1:0] raw_det;
  logic [NK-1:0] in_sld;
  logic [3:0]    nsld;
  logic [NK-1:0] own_r;
  logic          sld_own_r;

  // 0..1 keys cannot form a slider; clamp length to at most NSMAX
  assign nsld = (slider_len > 4'(NSMAX)) ? 4'(NSMAX) : slider_len;

  genvar g;
  generate
    for (g = 0; g < NK; g++) begin : g_key
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_r[g] <= 4'h0;
        end else if (acq_valid) begin
          if (!above_thr[g]) cnt_r[g] <= 4'h0;
          else if (cnt_r[g] != DI_LIM) cnt_r[g] <= cnt_r[g] + 4'h1;
        end
      end
      assign raw_det[g] = (cnt_r[g] == DI_LIM);
      assign in_sld[g]  = (nsld >= 4'd2) && (4'(g) < nsld);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // suppression: one owner per group 1..3, group 0 exempt; slider is a single object
  function automatic sks_pkg::sks_grp_t grp_of(input int k);
    grp_of = neighbour_suppression_group[k*2 +: 2];
  endfunction : grp_of

  logic [NK-1:0] grp0_m;
  logic [NK-1:0] grp1_m;
  logic [NK-1:0] grp2_m;
  logic [NK-1:0] grp3_m;
  logic [NK-1:0] sld_grp_m;
  logic [NK-1:0] held_own;
  logic [NK-1:0] free_det;

  // slices, not grp_of: a continuous assign would not follow the port through a call
  generate
    for (g = 0; g < NK; g++) begin : g_grp
      assign grp0_m[g] = (neighbour_suppression_group[g*2 +: 2] == 2'h0);
      assign grp1_m[g] = (neighbour_suppression_group[g*2 +: 2] == 2'h1);
      assign grp2_m[g] = (neighbour_suppression_group[g*2 +: 2] == 2'h2);
      assign grp3_m[g] = (neighbour_suppression_group[g*2 +: 2] == 2'h3);
    end
  endgenerate

  logic          sld_raw;
  logic [1:0]    sld_grp;
  logic [NK-1:0] own_nxt;
  logic          sld_own_nxt;
  logic [NK-1:0] key_rep;
  logic          sld_rep;

  assign sld_raw = |(raw_det & in_sld);
  assign sld_grp = neighbour_suppression_group[1:0];
  assign sld_grp_m = (sld_grp == 2'h1) ? grp1_m : (sld_grp == 2'h2) ? grp2_m : grp3_m;
  assign held_own = own_r & raw_det & ~in_sld;
  assign free_det = raw_det & ~in_sld & grp0_m;

  always_comb begin
    logic [3:0] busy;
    busy        = 4'h0;
    own_nxt     = held_own;
    sld_own_nxt = sld_own_r & sld_raw;
    if (sld_own_nxt) busy[sld_grp] = 1'b1;
    for (int k = 0; k < NK; k++) begin
      if (own_nxt[k]) busy[grp_of(k)] = 1'b1;
    end
    // an existing owner wins; free groups go to slider, then lowest key
    if (sld_raw && !sld_own_nxt && (sld_grp == 2'd0 || !busy[sld_grp])) begin
      sld_own_nxt = 1'b1;
      busy[sld_grp] = 1'b1;
    end
    for (int k = 0; k < NK; k++) begin
      if (raw_det[k] && !in_sld[k] && !own_nxt[k]) begin
        if (grp_of(k) == 2'd0) begin
          own_nxt[k] = 1'b1;
        end else if (!busy[grp_of(k)]) begin
          own_nxt[k] = 1'b1;
          busy[grp_of(k)] = 1'b1;
        end
      end
    end
    busy[0] = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      own_r     <= '0;
      sld_own_r <= 1'b0;
    end else begin
      own_r     <= own_nxt;
      sld_own_r <= sld_own_nxt;
    end
  end

  // slider keys all report together when the slider owns its group
  assign key_rep = own_r | (in_sld & raw_det & {NK{sld_own_r}});
  assign sld_rep = sld_own_r;

  ////////////////////////////////////////////////////////////////////////////
  // centroid over detected slider keys, 8-bit then truncated to pos_bits held within 2..8
  // eight keys at full delta weigh up to 7140, so 13 bits
  logic [12:0] wsum;
  logic [11:0] dsum;
  logic [7:0]  pos8;
  logic [7:0]  pos_q;
  logic [3:0]  res;

  always_comb begin
    wsum = 13'h0;
    dsum = 12'h0;
    for (int k = 0; k < NSMAX; k++) begin
      if (in_sld[k] && raw_det[k]) begin
        wsum = wsum + 13'(k) * 13'(key_delta[k*8 +: 8]);
        dsum = dsum + 12'(key_delta[k*8 +: 8]);
      end
    end
  end

  // divider is combinational; fine at slow acquisition rate, costs area
  logic [20:0] num;
  assign num  = (nsld > 4'h1) ? 21'(wsum) * 21'hff : 21'h0;
  assign pos8 = (dsum == 12'h0) ? 8'h0
              : 8'(num / (21'(dsum) * 21'(nsld - 4'h1)));
  assign res  = (pos_bits < `SKS_RES_MIN) ? `SKS_RES_MIN
              : (pos_bits > `SKS_RES_MAX) ? `SKS_RES_MAX : pos_bits;
  assign pos_q = pos8 >> (4'd8 - res);

  ////////////////////////////////////////////////////////////////////////////
  sks_pkg::sks_status_s st_nxt;
  assign st_nxt.key_det = key_rep;
  assign st_nxt.sld_det = sld_rep;
  // owner flag lags the release by a cycle; no keys left means no fresh position
  assign st_nxt.sld_pos = (sld_rep && sld_raw) ? pos_q : status_r.sld_pos;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r      <= '0;
      change_n_o_r  <= 1'b0;
      change_n_oe_r <= 1'b0;
    end else begin
      status_r <= st_nxt;
      if (st_nxt != status_r) change_n_oe_r <= 1'b1;
      else if (change_clr)    change_n_oe_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_integ_clear: assert property (@(posedge clk) disable iff (!arst_n)
    acq_valid && !above_thr[0] |=> cnt_r[0] == 4'h0)
    else $error("integrator not cleared");
  chk_integ_limit: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_r[0] <= DI_LIM) else $error("integrator over limit");
  chk_change_set: assert property (@(posedge clk) disable iff (!arst_n)
    st_nxt != status_r |=> change_n_oe_r) else $error("change not asserted");
  chk_pos_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !sld_rep |=> $stable(status_r.sld_pos)) else $error("position moved");
  chk_pos_range: assert property (@(posedge clk) disable iff (!arst_n)
    sld_rep && sld_raw |=> (status_r.sld_pos >> $past(res)) == 8'h0)
    else $error("position wide");
  chk_sld_gone: assert property (@(posedge clk) disable iff (!arst_n)
    !sld_raw |-> ##2 !status_r.sld_det) else $error("slider flag stuck");
  chk_sld_object: assert property (@(posedge clk) disable iff (!arst_n)
    sld_own_r |-> (key_rep & in_sld) == (raw_det & in_sld)) else $error("slider key lost");
  chk_owner_hold: assert property (@(posedge clk) disable iff (!arst_n)
    held_own != '0 |=> ($past(held_own) & ~own_r) == '0)
    else $error("owner dropped");
  chk_exempt_key: assert property (@(posedge clk) disable iff (!arst_n)
    free_det != '0 |=> ($past(free_det) & ~own_r) == '0)
    else $error("exempt key suppressed");
  // group checks skip cycles in which the host regroups keys
  chk_sld_first: assert property (@(posedge clk) disable iff (!arst_n)
    sld_own_r && sld_grp != 2'h0 && $stable(neighbour_suppression_group)
    |-> (own_r & ~in_sld & sld_grp_m) == '0) else $error("slider lost group");
  chk_one_owner: assert property (@(posedge clk) disable iff (!arst_n)
    $stable(neighbour_suppression_group) |-> $onehot0(own_r & grp1_m)
    && $onehot0(own_r & grp2_m) && $onehot0(own_r & grp3_m)) else $error("group shared");
  chk_change_clear: assert property (@(posedge clk) disable iff (!arst_n)
    st_nxt == status_r && change_clr |=> !change_n_oe_r) else $error("change stuck");
endmodule : sks_core
`default_nettype wire

// ===== verif/sks_host.sv
// host model that acknowledges the change line
`timescale 1ns/1ns
`default_nettype none
module sks_host #(parameter int DLY = 3) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic change_n_oe_r,
  output var  logic change_clr,
  output var  int   acks
);
  int wait_r;
  // a slow host reads the status some cycles after the line falls
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 0;
      change_clr <= 1'b0;
      acks <= 0;
    end else if (change_n_oe_r && !change_clr && wait_r < DLY) begin
      wait_r <= wait_r + 1;
    end else if (change_n_oe_r && !change_clr) begin
      change_clr <= 1'b1;
      acks <= acks + 1;
      wait_r <= 0;
    end else begin
      change_clr <= 1'b0;
    end
  end
endmodule : sks_host
`default_nettype wire

// ===== verif/sks_core_bench.sv
// self-checking bench for the slider and key suppression block
`timescale 1ns/1ns
`default_nettype none
module sks_core_bench;
  logic clk = 0, arst_n = 0, acq_valid = 0, oe, change_clr, line_o;
  logic [15:0] above_thr = '0;
  logic [127:0] key_delta = '0;
  logic [3:0] slider_len = 4'h0, pos_bits = 4'h8;
  logic [31:0] grp = '0;
  sks_pkg::sks_status_s st;
  int acks, err_count = 0, total_checks = 0, cnt[16];
  sks_core i_sks_core (.clk(clk), .arst_n(arst_n), .acq_valid(acq_valid),
    .above_thr(above_thr), .key_delta(key_delta), .slider_len(slider_len),
    .pos_bits(pos_bits), .neighbour_suppression_group(grp), .change_clr(change_clr),
    .status_r(st), .change_n_o_r(line_o), .change_n_oe_r(oe));
  sks_host i_sks_host (.clk(clk), .arst_n(arst_n), .change_n_oe_r(oe),
    .change_clr(change_clr), .acks(acks));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // n acquisitions of one mask, deltas random and never zero
  task automatic acq(input logic [15:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      acq_valid <= 1'b1;
      above_thr <= m;
      for (int k = 0; k < 128; k += 8) key_delta[k+:8] <= 8'($urandom_range(255, 1));
      for (int k = 0; k < 16; k++) cnt[k] = m[k] ? cnt[k] + 1 : 0;
    end
    @(posedge clk);
    acq_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : acq
  task automatic keys(input logic [15:0] allow, input logic sd);
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[k] = cnt[k] >= 4;
    chk("key_det", 32'(st.key_det), 32'(r & allow));
    chk("sld_det", 32'(st.sld_det), 32'(sd));
  endtask : keys
  task automatic ack(input int a0);
    chk("change_oe", 32'(oe), 32'h1);
    for (int i = 0; i < 50 && acks == a0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("change", 32'(acks > a0), 32'h1);
    if (acks == a0) summarize();
    @(posedge clk);
    #1;
    chk("change_oe", 32'(oe), 32'h0);
    chk("change_line", 32'(line_o), 32'h0);
  endtask : ack
  initial begin
    int a0, ws, ds;
    void'($urandom(32'h43811c67));
    foreach (cnt[k]) cnt[k] = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    a0 = acks;
    acq(16'h1000, 3);
    acq(16'h0000, 1);
    acq(16'h1000, 3);
    keys(16'hffff, 1'b0);
    acq(16'h1000, 1);
    keys(16'hffff, 1'b0);
    ack(a0);
    $display("test integrator done");
    grp <= 32'h0014_0000;
    acq(16'h0200, 4);
    acq(16'h0600, 4);
    keys(16'hfbff, 1'b0);
    acq(16'h0400, 4);
    keys(16'hffff, 1'b0);
    $display("test groups done");
    slider_len <= 4'h4;
    grp <= 32'h0094_00aa;
    acq(16'h0800, 4);
    acq(16'h0806, 4);
    keys(16'hfff9, 1'b0);
    acq(16'h0000, 1);
    acq(16'h0016, 4);
    keys(16'hffff, 1'b1);
    acq(16'h0816, 4);
    keys(16'hf7ff, 1'b1);
    acq(16'h0000, 1);
    $display("test slider groups done");
    for (int b = 2; b <= 8; b++) begin
      pos_bits <= 4'(b);
      acq(16'h0008, 4);
      chk("sld_pos", 32'(st.sld_pos), 32'((1 << b) - 1));
      acq(16'h0000, 1);
      keys(16'hffff, 1'b0);
      chk("sld_pos", 32'(st.sld_pos), 32'((1 << b) - 1));
    end
    acq(16'h0001, 4);
    chk("sld_pos", 32'(st.sld_pos), 32'h0);
    $display("test position done");
    acq(16'h0000, 1);
    slider_len <= 4'hf;
    grp <= 32'h0094_aaaa;
    acq(16'h00e0, 4);
    keys(16'hffff, 1'b1);
    ws = 0;
    ds = 0;
    for (int k = 5; k < 8; k++) begin
      ws += k * int'(key_delta[k*8+:8]);
      ds += int'(key_delta[k*8+:8]);
    end
    chk("sld_pos", 32'(st.sld_pos), 32'((ws * 255) / (ds * 7)));
    acq(16'h0000, 1);
    pos_bits <= 4'h0;
    acq(16'h0080, 4);
    chk("sld_pos", 32'(st.sld_pos), 32'h3);
    $display("test centroid done");
    summarize();
  end
  initial begin
    #500000;
    chk("timeout", 32'h0, 32'h1);
    summarize();
  end
endmodule : sks_core_bench
`default_nettype wire
